//--- amn_pkg.sv
package amn_pkg;

    // Register map, one aligned 32-bit word each
    localparam logic [7:0] OFF_STATUS  = 8'h00;
    localparam logic [7:0] OFF_MASK    = 8'h04;
    localparam logic [7:0] OFF_SUMMARY = 8'h08;
    localparam logic [7:0] OFF_CTRL    = 8'h0C;
    localparam logic [7:0] OFF_STATE   = 8'h10;

    // Alarm source bit positions
    localparam int ALM_FIFO   = 0;
    localparam int ALM_PLL    = 1;
    localparam int ALM_LINK   = 2;
    localparam int ALM_REALGN = 3;
    localparam int ALM_OSC    = 4;
    localparam int ALM_CLK    = 5;
    localparam int NUM_ALM    = 6;

    // Control field positions
    localparam int CTL_LINK_EN  = 0;
    localparam int CTL_PIN_SEL  = 1;
    localparam int CTL_SYNC_SRC = 2;
    localparam int CTL_SUBCL0   = 3;
    localparam int CTL_ENC66    = 4;

    // Reset values
    localparam logic [5:0] MASK_RST = 6'h3F;
    localparam logic [4:0] CTRL_RST = 5'h00;

    // Local multiframe counter period in device clocks
    localparam int MF_PERIOD = 32;

    typedef struct packed {
        logic fifoErr;
        logic pllUnlock;
        logic linkInData;
        logic clkAUpset;
        logic clkBUpset;
    } amn_src_t;

    typedef struct packed {
        logic linkReset;
        logic serPowerDown;
        logic linkClkGate;
    } amn_link_t;

endpackage

//--- amn_acc_cmp.sv
`timescale 1ns/1ps
// Registered compare of the two accumulator banks
module amn_acc_cmp #(
    parameter int WIDTH = 32,
    parameter int NACC  = 4
) (
    input  wire logic                  core_clk,
    input  wire logic                  rstn,
    input  wire logic [NACC*WIDTH-1:0] accA,
    input  wire logic [NACC*WIDTH-1:0] accB,
    output logic                       differ
);
    // Any bit difference in any cycle counts, so no filtering here
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            differ <= 1'b0;
        end else begin
            differ <= (accA != accB);
        end
    end
endmodule

//--- amn_alarm_monitor.sv
`timescale 1ns/1ps
module amn_alarm_monitor #(
    parameter int ACC_W  = 32,
    parameter int NACC   = 4
) (
    input  wire logic                   core_clk,
    input  wire logic                   rstn,
    input  wire logic                   hsel,
    input  wire logic [31:0]            haddr,
    input  wire logic [1:0]             htrans,
    input  wire logic                   hwrite,
    input  wire logic [2:0]             hsize,
    input  wire logic [31:0]            hwdata,
    input  wire logic                   hready,
    output logic                        hreadyout,
    output logic                        hresp,
    output logic [31:0]                 hrdata,
    input  wire amn_pkg::amn_src_t      srcIn,
    input  wire logic                   refPulseIn,
    input  wire logic                   ilaStart,
    input  wire logic [NACC*ACC_W-1:0]  accA,
    input  wire logic [NACC*ACC_W-1:0]  accB,
    output amn_pkg::amn_link_t          linkCtl,
    output logic                        mfClkEdge,
    output logic                        cal_status_pin,
    output logic                        alarmSummary
);
    ////////////////////////////////////////////////////////////////////////
    // Pin inputs through two flip-flops
    logic       refMeta_reg;
    logic       refSync_reg;
    logic       refPrev_reg;
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            refMeta_reg <= 1'b0;
            refSync_reg <= 1'b0;
            refPrev_reg <= 1'b0;
        end else begin
            refMeta_reg <= refPulseIn;
            refSync_reg <= refMeta_reg;
            refPrev_reg <= refSync_reg;
        end
    end
    logic refRise;
    assign refRise = refSync_reg & ~refPrev_reg;

    ////////////////////////////////////////////////////////////////////////
    // AHB-Lite slave, zero wait states, always OKAY
    logic        wrPend_reg;
    logic        rdPend_reg;
    logic [7:0]  addr_reg;
    logic        accept;
    assign accept = hsel & hready & htrans[1];
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    // Capture the address phase for the data phase
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            wrPend_reg <= 1'b0;
            rdPend_reg <= 1'b0;
            addr_reg   <= 8'h00;
        end else begin
            wrPend_reg <= accept & hwrite;
            rdPend_reg <= accept & ~hwrite;
            if (accept) begin
                addr_reg <= haddr[7:0];
            end
        end
    end

    function automatic logic hits(input logic [7:0] a, input logic [7:0] o);
        return a[7:2] == o[7:2];
    endfunction

    logic wrStatus;
    logic wrMask;
    logic wrCtrl;
    assign wrStatus = wrPend_reg & hits(addr_reg, amn_pkg::OFF_STATUS);
    assign wrMask   = wrPend_reg & hits(addr_reg, amn_pkg::OFF_MASK);
    assign wrCtrl   = wrPend_reg & hits(addr_reg, amn_pkg::OFF_CTRL);

    ////////////////////////////////////////////////////////////////////////
    // Mask and control registers
    logic [5:0] mask_reg;
    logic [4:0] ctrl_reg;
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            mask_reg <= amn_pkg::MASK_RST;
            ctrl_reg <= amn_pkg::CTRL_RST;
        end else begin
            if (wrMask) begin
                mask_reg <= hwdata[5:0];
            end
            if (wrCtrl) begin
                ctrl_reg <= hwdata[4:0];
            end
        end
    end
    logic linkEn;
    assign linkEn = ctrl_reg[amn_pkg::CTL_LINK_EN];

    always_comb begin
        linkCtl.linkReset    = ~linkEn;
        linkCtl.serPowerDown = ~linkEn;
        linkCtl.linkClkGate  = ~linkEn;
    end

    ////////////////////////////////////////////////////////////////////////
    // Local multiframe clock; counter restarts on reference pulse unless subclass 0 is set
    // Wrap point kept explicit so a shorter period only needs the constant
    localparam logic [4:0] MF_LAST = 5'(amn_pkg::MF_PERIOD - 1);
    logic [4:0] mfCnt_reg;
    logic       realign;
    assign realign = refRise & linkEn & ~ctrl_reg[amn_pkg::CTL_SUBCL0]
                     & (mfCnt_reg != 5'h00);
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            mfCnt_reg <= 5'h00;
        end else if (!linkEn) begin
            mfCnt_reg <= 5'h00;
        end else if (refRise & ~ctrl_reg[amn_pkg::CTL_SUBCL0]) begin
            mfCnt_reg <= 5'h00;
        end else if (mfCnt_reg == MF_LAST) begin
            mfCnt_reg <= 5'h00;
        end else begin
            mfCnt_reg <= mfCnt_reg + 5'h01;
        end
    end
    assign mfClkEdge = linkEn & (mfCnt_reg == 5'h00);

    ////////////////////////////////////////////////////////////////////////
    // Oscillator sync arming
    logic oscArmed_reg;
    logic oscSyncEv;
    assign oscSyncEv = ctrl_reg[amn_pkg::CTL_SYNC_SRC] ? ilaStart : refRise;
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            oscArmed_reg <= 1'b0;
        end else if (!linkEn) begin
            oscArmed_reg <= 1'b0;
        end else if (oscSyncEv) begin
            oscArmed_reg <= 1'b1;
        end
    end

    logic accDiffer;
    amn_acc_cmp #(
        .WIDTH (ACC_W),
        .NACC  (NACC)
    ) u_cmp (
        .core_clk (core_clk),
        .rstn     (rstn),
        .accA     (accA),
        .accB     (accB),
        .differ   (accDiffer)
    );

    ////////////////////////////////////////////////////////////////////////
    // Source events
    logic [5:0] events;
    always_comb begin
        events = 6'h00;
        events[amn_pkg::ALM_FIFO] = srcIn.fifoErr;
        events[amn_pkg::ALM_PLL]  = srcIn.pllUnlock;
        events[amn_pkg::ALM_LINK] = linkEn & ~srcIn.linkInData;
        events[amn_pkg::ALM_REALGN] = realign;
        events[amn_pkg::ALM_OSC] = oscArmed_reg & accDiffer;
        events[amn_pkg::ALM_CLK] = srcIn.clkAUpset ^ srcIn.clkBUpset;
    end

    ////////////////////////////////////////////////////////////////////////
    // Sticky status bits
    logic [5:0] status_reg;
    logic [5:0] status_next;
    logic [5:0] clrBits;
    assign clrBits = wrStatus ? hwdata[5:0] : 6'h00;
    assign status_next = (status_reg & ~clrBits) | events;
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            status_reg <= 6'h00;
        end else begin
            status_reg <= status_next;
        end
    end

    logic osc_mismatch_flag;
    logic clock_upset_flag;
    assign osc_mismatch_flag = status_reg[amn_pkg::ALM_OSC];
    assign clock_upset_flag  = status_reg[amn_pkg::ALM_CLK];

    assign alarmSummary = |(status_reg & ~mask_reg);
    assign cal_status_pin = ctrl_reg[amn_pkg::CTL_PIN_SEL] & alarmSummary;

    ////////////////////////////////////////////////////////////////////////
    // Read data, registered at the address phase; unmapped reads zero
    logic [31:0] rdata_next;
    always_comb begin
        rdata_next = 32'h0000_0000;
        if (hits(haddr[7:0], amn_pkg::OFF_STATUS)) begin
            rdata_next[5:0] = status_next;
        end else if (hits(haddr[7:0], amn_pkg::OFF_MASK)) begin
            // Forward a write still in its data phase
            rdata_next[5:0] = wrMask ? hwdata[5:0] : mask_reg;
        end else if (hits(haddr[7:0], amn_pkg::OFF_SUMMARY)) begin
            rdata_next[0] = alarmSummary;
        end else if (hits(haddr[7:0], amn_pkg::OFF_CTRL)) begin
            // Back to back read sees the landing write
            rdata_next[4:0] = wrCtrl ? hwdata[4:0] : ctrl_reg;
        end else if (hits(haddr[7:0], amn_pkg::OFF_STATE)) begin
            rdata_next[4:0] = mfCnt_reg;
            rdata_next[8]   = oscArmed_reg;
        end
    end
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            hrdata <= 32'h0000_0000;
        end else if (accept & ~hwrite) begin
            hrdata <= rdata_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    AST_STICKY: assert property (@(posedge core_clk) disable iff (!rstn)
        $past(status_reg[0]) & ~$past(clrBits[0]) |-> status_reg[0])
        else $error("status bit dropped without clear");
    AST_SETWINS: assert property (@(posedge core_clk) disable iff (!rstn)
        events[1] |=> status_reg[1])
        else $error("event lost");
    AST_SUMMARY: assert property (@(posedge core_clk) disable iff (!rstn)
        |(events & ~mask_reg) & ~wrMask |=> alarmSummary)
        else $error("unmasked alarm not summarised");
    AST_MSK: assert property (@(posedge core_clk) disable iff (!rstn)
        &mask_reg |-> !alarmSummary)
        else $error("masked alarm in summary");
    AST_PIN: assert property (@(posedge core_clk) disable iff (!rstn)
        ctrl_reg[amn_pkg::CTL_PIN_SEL] & |(events & ~mask_reg) & ~wrMask
            & ~wrCtrl |=> cal_status_pin)
        else $error("pin not high");
    AST_LINKOFF: assert property (@(posedge core_clk) disable iff (!rstn)
        !linkEn |-> linkCtl.linkReset & linkCtl.serPowerDown
            & linkCtl.linkClkGate)
        else $error("link not held off");
    AST_IDLE: assert property (@(posedge core_clk) disable iff (!rstn)
        linkEn & ~srcIn.linkInData |=> status_reg[2])
        else $error("idle alarm missing");
    AST_OSC: assert property (@(posedge core_clk) disable iff (!rstn)
        !oscArmed_reg & !osc_mismatch_flag |=> !osc_mismatch_flag)
        else $error("mismatch before sync");
    AST_MIS: assert property (@(posedge core_clk) disable iff (!rstn)
        oscArmed_reg & accDiffer |=> osc_mismatch_flag)
        else $error("armed mismatch not flagged");
    AST_REAL: assert property (@(posedge core_clk) disable iff (!rstn)
        realign |=> status_reg[amn_pkg::ALM_REALGN])
        else $error("realign alarm missing");
    AST_FIFO: assert property (@(posedge core_clk) disable iff (!rstn)
        srcIn.fifoErr |=> status_reg[amn_pkg::ALM_FIFO])
        else $error("fifo alarm missing");
    AST_MFRST: assert property (@(posedge core_clk) disable iff (!rstn)
        refRise & linkEn & ~ctrl_reg[3] |=> mfCnt_reg == 5'h00)
        else $error("multiframe not reset");
    AST_CLK: assert property (@(posedge core_clk) disable iff (!rstn)
        srcIn.clkAUpset != srcIn.clkBUpset |=> clock_upset_flag)
        else $error("clock flag missing");
    COV_OSC: cover property (@(posedge core_clk) osc_mismatch_flag);
    COV_CLR: cover property (@(posedge core_clk) wrStatus & |status_reg);
    COV_PIN: cover property (@(posedge core_clk) cal_status_pin);
    COV_REAL: cover property (@(posedge core_clk) realign);
endmodule

//--- amn_alarm_monitor_tb.sv
`timescale 1ns/1ps
module amn_alarm_monitor_tb;
    localparam int AW = 128;
    logic               core_clk;
    logic               rstn;
    logic               hsel;
    logic [31:0]        haddr;
    logic [1:0]         htrans;
    logic               hwrite;
    logic [2:0]         hsize;
    logic [31:0]        hwdata;
    logic               hreadyout;
    logic               hresp;
    logic [31:0]        hrdata;
    amn_pkg::amn_src_t  srcIn;
    amn_pkg::amn_src_t  idleSrc;
    logic               refPulseIn;
    logic               ilaStart;
    logic [AW-1:0]      accA;
    logic [AW-1:0]      accB;
    amn_pkg::amn_link_t linkCtl;
    logic               mfClkEdge;
    logic               cal_status_pin;
    logic               alarmSummary;
    logic [31:0]        rd;
    logic [31:0]        expS;
    int                 n_fail;
    int                 samples_checked;
    int                 n;

    // Single slave, so its ready is the bus ready
    amn_alarm_monitor i_amn_alarm_monitor (
        .core_clk(core_clk), .rstn(rstn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
        .hrdata(hrdata), .srcIn(srcIn), .refPulseIn(refPulseIn),
        .ilaStart(ilaStart), .accA(accA), .accB(accB), .linkCtl(linkCtl),
        .mfClkEdge(mfClkEdge), .cal_status_pin(cal_status_pin),
        .alarmSummary(alarmSummary)
    );

    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic cyc(input int k);
        repeat (k) @(posedge core_clk);
    endtask

    task automatic bad(input string m);
        n_fail++;
        $display("unexpected at %0t: %s", $time, m);
    endtask

    task automatic chk32(input logic [31:0] g, input logic [31:0] e,
                         input string m);
        samples_checked++;
        if (g !== e) bad($sformatf("%s got %h exp %h", m, g, e));
    endtask

    task automatic chk1(input logic g, input logic e, input string m);
        samples_checked++;
        if (g !== e) bad(m);
    endtask

    // Bounded wait so a stuck slave cannot hang the bus task
    task automatic waitReady;
        int k;
        k = 0;
        @(posedge core_clk);
        while (hreadyout !== 1'b1 && k < 50) begin
            k++;
            @(posedge core_clk);
        end
        if (hreadyout !== 1'b1) bad("no ready");
    endtask

    task automatic ahbWr(input logic [7:0] off, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= {24'h000000, off};
        htrans <= 2'b10;
        hwrite <= 1'b1;
        hsize <= 3'b010;
        waitReady;
        htrans <= 2'b00;
        hsel <= 1'b0;
        hwdata <= d;
        waitReady;
    endtask

    task automatic ahbRd(input logic [7:0] off, output logic [31:0] d);
        hsel <= 1'b1;
        haddr <= {24'h000000, off};
        htrans <= 2'b10;
        hwrite <= 1'b0;
        hsize <= 3'b010;
        waitReady;
        htrans <= 2'b00;
        hsel <= 1'b0;
        waitReady;
        d = hrdata;
    endtask

    task automatic rdChk(input logic [7:0] off, input logic [31:0] e,
                         input string m);
        ahbRd(off, rd);
        chk32(rd, e, m);
    endtask

    // Edge count from the end of a three-cycle reference pulse to the next multiframe edge
    task automatic refPulse;
        n = 0;
        while (mfClkEdge !== 1'b1 && n < 100) begin
            n++;
            @(posedge core_clk);
        end
        cyc(10);
        refPulseIn <= 1'b1;
        cyc(3);
        refPulseIn <= 1'b0;
        n = 0;
        while (mfClkEdge !== 1'b1 && n < 40) begin
            n++;
            @(posedge core_clk);
        end
    endtask

    task automatic results;
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // Full run is near 215 cycles
    initial begin
        repeat (20000) @(posedge core_clk);
        bad("watchdog expired");
        results;
    end

    ////////////////////////////////////////////////////////////////////////
    initial begin
        n_fail = 0;
        samples_checked = 0;
        idleSrc = '{fifoErr: 1'b0, pllUnlock: 1'b0, linkInData: 1'b1,
                    clkAUpset: 1'b0, clkBUpset: 1'b0};
        {hsel, htrans, hwrite, haddr, hwdata} = '0;
        hsize = 3'b010;
        srcIn = idleSrc;
        {refPulseIn, ilaStart} = 2'b00;
        accA = {4{32'h13579BDF}};
        accB = accA;
        rstn = 1'b0;
        cyc(20);
        rstn <= 1'b1;
        cyc(1);
        // Reset values and an unmapped word
        chk32({hreadyout, hresp, linkCtl}, 5'h17, "reset pins");
        rdChk(amn_pkg::OFF_STATUS, 32'h00000000, "status rst");
        rdChk(amn_pkg::OFF_MASK, 32'h0000003F, "mask rst");
        rdChk(amn_pkg::OFF_CTRL, 32'h00000000, "ctrl rst");
        rdChk(8'h20, 32'h00000000, "unmapped");
        $display("test reset done");
        // FIFO, PLL and clock sources each set their own bit while masked out of summary
        expS = '0;
        for (int i = 0; i < 3; i++) begin
            case (i)
                0: srcIn.fifoErr <= 1'b1;
                1: srcIn.pllUnlock <= 1'b1;
                default: srcIn.clkAUpset <= 1'b1;
            endcase
            cyc(3);
            srcIn <= idleSrc;
            cyc(3);
            expS |= (i == 0) ? 32'h1 << amn_pkg::ALM_FIFO :
                    (i == 1) ? 32'h1 << amn_pkg::ALM_PLL :
                    32'h1 << amn_pkg::ALM_CLK;
            rdChk(amn_pkg::OFF_STATUS, expS, "sticky set");
            chk1(alarmSummary, 1'b0, "masked summary");
        end
        ahbWr(amn_pkg::OFF_STATUS, 32'h00000000);
        rdChk(amn_pkg::OFF_STATUS, expS, "zero write");
        ahbWr(amn_pkg::OFF_STATUS, 32'h1 << amn_pkg::ALM_PLL);
        expS &= ~(32'h1 << amn_pkg::ALM_PLL);
        rdChk(amn_pkg::OFF_STATUS, expS, "one clear");
        ahbWr(amn_pkg::OFF_STATUS, 32'h0000003F);
        rdChk(amn_pkg::OFF_STATUS, 32'h00000000, "clear all");
        $display("test sticky done");
        // Summary and status pin with only the FIFO alarm unmasked
        ahbWr(amn_pkg::OFF_MASK, 32'h0000003E);
        srcIn.pllUnlock <= 1'b1;
        cyc(3);
        chk1(alarmSummary, 1'b0, "masked pll");
        srcIn.pllUnlock <= 1'b0;
        srcIn.fifoErr <= 1'b1;
        cyc(3);
        chk1(alarmSummary, 1'b1, "summary");
        rdChk(amn_pkg::OFF_SUMMARY, 32'h00000001, "summary reg");
        chk1(cal_status_pin, 1'b0, "pin unselected");
        ahbWr(amn_pkg::OFF_CTRL, 32'h1 << amn_pkg::CTL_PIN_SEL);
        cyc(1);
        chk1(cal_status_pin, 1'b1, "pin alarm");
        // Clearing write while the source still fires
        ahbWr(amn_pkg::OFF_STATUS, 32'h0000003F);
        srcIn <= idleSrc;
        cyc(2);
        rdChk(amn_pkg::OFF_STATUS, 32'h1, "set wins");
        ahbWr(amn_pkg::OFF_STATUS, 32'h0000003F);
        cyc(1);
        chk32({alarmSummary, cal_status_pin}, 2'b00, "pins clear");
        $display("test summary done");
        // Link not sending data only matters once enabled
        srcIn.linkInData <= 1'b0;
        cyc(3);
        rdChk(amn_pkg::OFF_STATUS, 32'h0, "link off");
        ahbWr(amn_pkg::OFF_CTRL, 32'h00000003);
        cyc(1);
        chk32(linkCtl, 3'b000, "link on ctl");
        cyc(3);
        srcIn <= idleSrc;
        cyc(2);
        rdChk(amn_pkg::OFF_STATUS, 32'h1 << amn_pkg::ALM_LINK, "idle");
        ahbWr(amn_pkg::OFF_STATUS, 32'h0000003F);
        $display("test link done");
        // Mismatch ignored until synced, then one cycle is enough
        accB <= ~accA;
        cyc(1);
        accB <= accA;
        cyc(4);
        rdChk(amn_pkg::OFF_STATUS, 32'h0, "unarmed");
        refPulse;
        chk1(n < 10, 1'b1, "ref restarts frame");
        expS = 32'h1 << amn_pkg::ALM_REALGN;
        rdChk(amn_pkg::OFF_STATUS, expS, "realign");
        ahbRd(amn_pkg::OFF_STATE, rd);
        chk1(rd[8], 1'b1, "armed by ref");
        accB <= ~accA;
        cyc(1);
        accB <= accA;
        cyc(5);
        expS |= 32'h1 << amn_pkg::ALM_OSC;
        rdChk(amn_pkg::OFF_STATUS, expS, "osc upset");
        ahbWr(amn_pkg::OFF_STATUS, 32'h0000003F);
        $display("test osc ref done");
        // Lane alignment start as sync source
        ahbWr(amn_pkg::OFF_CTRL, 32'h00000000);
        ahbWr(amn_pkg::OFF_CTRL, 32'h1 | (32'h1 << amn_pkg::CTL_SYNC_SRC));
        ahbRd(amn_pkg::OFF_STATE, rd);
        chk1(rd[8], 1'b0, "disarmed");
        ilaStart <= 1'b1;
        cyc(1);
        ilaStart <= 1'b0;
        cyc(3);
        ahbRd(amn_pkg::OFF_STATE, rd);
        chk1(rd[8], 1'b1, "armed by ila");
        $display("test osc ila done");
        // Subclass 0 ignores the reference and free-runs the frame
        ahbWr(amn_pkg::OFF_CTRL, 32'h00000000);
        ahbWr(amn_pkg::OFF_CTRL, 32'h1 | (32'h1 << amn_pkg::CTL_SUBCL0));
        refPulse;
        chk1(n > 10 && n <= amn_pkg::MF_PERIOD, 1'b1, "self frame");
        cyc(4);
        rdChk(amn_pkg::OFF_STATUS, 32'h0, "no realign");
        ahbWr(amn_pkg::OFF_CTRL, 32'h00000000);
        cyc(1);
        chk32(linkCtl, 3'b111, "link off ctl");
        $display("test subclass0 done");
        // Second reset mid-run brings the mask back
        rstn <= 1'b0;
        cyc(2);
        rstn <= 1'b1;
        cyc(1);
        rdChk(amn_pkg::OFF_MASK, 32'h0000003F, "mask rst again");
        $display("test reset again done");
        results;
    end
endmodule
